// *** design/gpd_pkg.sv ***
// Constants and types shared by the general-purpose port data and direction logic.
package gpd_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Widths and types.
    localparam int GPD_WIDTH = 8;

    typedef logic [GPD_WIDTH-1:0] gpd_byte_type;
    typedef logic [15:0]          gpd_addr_type;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Byte addresses of the two port registers on the processor's register space.
    localparam gpd_addr_type GPD_DATA_ADDR = 16'hFFD6;
    localparam gpd_addr_type GPD_DIR_ADDR  = 16'hFFE6;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed read values.
    localparam gpd_byte_type GPD_LATCH_RST     = 8'h00;
    localparam gpd_byte_type GPD_DIR_RST       = 8'h00;
    localparam gpd_byte_type GPD_DIR_READ_VAL  = 8'hFF;
    localparam gpd_byte_type GPD_UNMAPPED_READ = 8'h00;
    localparam gpd_byte_type GPD_ALL_OUTPUT    = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Timing: read data appear this many clock edges after the read strobe.
    localparam int GPD_READ_LATENCY = 1;

endpackage

// *** design/gpd_bank_if.sv ***
// Interface carrying write strobes and port state between the decoder and the pin bank.
`timescale 1ns/1ps
`default_nettype none

interface gpd_bank_if;
    import gpd_pkg::*;

    // Write strobes and the byte being written.
    logic         wr_latch;
    logic         wr_dir;
    gpd_byte_type wdata;

    // State of the bank and the per-bit mixed read view.
    gpd_byte_type latch;
    gpd_byte_type dir;
    gpd_byte_type readback;

    modport ctrl (
        output wr_latch,
        output wr_dir,
        output wdata,
        input  latch,
        input  dir,
        input  readback
    );

    modport bank (
        input  wr_latch,
        input  wr_dir,
        input  wdata,
        output latch,
        output dir,
        output readback
    );

endinterface

`default_nettype wire

// *** design/gpd_pin_bank.sv ***
// Data latch, direction bits and per-pin read mix of the eight-pin port.
`timescale 1ns/1ps
`default_nettype none

module gpd_pin_bank
    import gpd_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Decoder side
    gpd_bank_if.bank                  bank,
    // Pins
    input  wire logic [GPD_WIDTH-1:0] pin_in,
    output logic      [GPD_WIDTH-1:0] pin_out,
    output logic      [GPD_WIDTH-1:0] pin_oe
);

    gpd_byte_type latch_reg;
    gpd_byte_type dir_reg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // The latch takes every written byte, also the bits of input pins, so that
    // turning a pin into an output later drives whatever software last stored.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= GPD_LATCH_RST;
        end else if (bank.wr_latch) begin
            latch_reg <= bank.wdata;
        end
    end

    // The direction bits are replaced as a whole byte; there is no per-bit write.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dir_reg <= GPD_DIR_RST;
        end else if (bank.wr_dir) begin
            dir_reg <= bank.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin drive comes straight from flip-flops, so the pads never see a glitch.
    assign pin_out = latch_reg;
    assign pin_oe  = dir_reg;

    assign bank.latch = latch_reg;
    assign bank.dir   = dir_reg;

    // Each bit reads its pin when it is an input and its latch when it is an output.
    for (genvar i = 0; i < GPD_WIDTH; i++) begin : g_mix
        assign bank.readback[i] = dir_reg[i] ? latch_reg[i] : pin_in[i];
    end

endmodule

`default_nettype wire

// *** design/gpd_port.sv ***
// Eight-pin port: processor byte access decode, read-back and pin bank.
`timescale 1ns/1ps
`default_nettype none

module gpd_port
    import gpd_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Processor byte access
    input  wire logic [15:0]          acc_addr,
    input  wire logic                 acc_rd,
    input  wire logic                 acc_wr,
    input  wire logic [GPD_WIDTH-1:0] acc_wdata,
    output logic      [GPD_WIDTH-1:0] acc_rdata,
    output logic                      acc_rd_valid,
    // Port pins
    input  wire logic [GPD_WIDTH-1:0] port_three_pins_in,
    output logic      [GPD_WIDTH-1:0] port_three_pins_out,
    output logic      [GPD_WIDTH-1:0] port_three_pins_oe
);

    gpd_bank_if bank_bus ();

    logic         sel_data;
    logic         sel_dir;
    gpd_byte_type rdata_reg;
    gpd_byte_type rdata_next;
    logic         rd_valid_reg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Address decode. One data address serves two purposes: writes go to the latch
    // and reads return the per-pin mix, so the decoder routes by direction of access.
    assign sel_data = (acc_addr == GPD_DATA_ADDR);
    assign sel_dir  = (acc_addr == GPD_DIR_ADDR);

    // Write strobes to the pin bank; the processor always writes whole bytes.
    assign bank_bus.wr_latch = acc_wr && sel_data;
    assign bank_bus.wr_dir   = acc_wr && sel_dir;
    assign bank_bus.wdata    = acc_wdata;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin bank.
    gpd_pin_bank u_bank (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .bank    (bank_bus.bank),
        .pin_in  (port_three_pins_in),
        .pin_out (port_three_pins_out),
        .pin_oe  (port_three_pins_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read data selection. The direction register has no read path at all, so a
    // bit operation aimed at it writes back ones for every other bit; software has
    // to work on a shadow copy instead.
    always_comb begin
        rdata_next = GPD_UNMAPPED_READ;
        if (sel_data) begin
            rdata_next = bank_bus.readback;
        end else if (sel_dir) begin
            rdata_next = GPD_DIR_READ_VAL;
        end
    end

    // Read data are held until the next read so the core may take them late.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= GPD_UNMAPPED_READ;
        end else if (acc_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // The valid pulse marks only reads that hit one of the two port addresses.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= acc_rd && (sel_data || sel_dir);
        end
    end

    assign acc_rdata    = rdata_reg;
    assign acc_rd_valid = rd_valid_reg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks on the port behaviour.
    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (!rst_n);

    // Input bits of a data read show the pins as they were at the read strobe.
    a_read_input_pins : assert property (
        (acc_rd && sel_data) |=>
            (((acc_rdata ^ $past(port_three_pins_in)) & ~$past(bank_bus.dir)) == 8'h00)
    ) else $error("Input bit of port read does not match pin level.");

    // Output bits of a data read show the latch, whatever the pin carries.
    a_read_output_latch : assert property (
        (acc_rd && sel_data) |=>
            (((acc_rdata ^ $past(bank_bus.latch)) & $past(bank_bus.dir)) == 8'h00)
    ) else $error("Output bit of port read does not match data latch.");

    // Direction reads return all ones together with the valid pulse.
    a_dir_read_ones : assert property (
        (acc_rd && sel_dir) |=> (acc_rd_valid && (acc_rdata == GPD_DIR_READ_VAL))
    ) else $error("Direction register read did not return all ones.");

    // Direction only moves on a direction write.
    a_dir_only_on_write : assert property (
        !(acc_wr && sel_dir) |=> $stable(port_three_pins_oe)
    ) else $error("Pin direction changed without a direction write.");

    // A data write shows on every enabled pin from the next cycle on.
    a_output_follows_write : assert property (
        (acc_wr && sel_data) |=>
            (((port_three_pins_out ^ $past(acc_wdata)) & port_three_pins_oe) == 8'h00)
    ) else $error("Driven pin level differs from written latch value.");

    // A data write stores all bits and leaves the direction alone.
    a_latch_all_bits : assert property (
        (acc_wr && sel_data) |=>
            ((bank_bus.latch == $past(acc_wdata)) && $stable(port_three_pins_oe))
    ) else $error("Data write did not store the full byte or moved direction.");

    // A direction write replaces all eight bits at once.
    a_dir_full_byte : assert property (
        (acc_wr && sel_dir) |=> (port_three_pins_oe == $past(acc_wdata))
    ) else $error("Direction write did not replace all eight bits.");

    // With all pins outputs, a read after a data write returns the written byte.
    sequence s_write_then_read;
        (acc_wr && sel_data && (port_three_pins_oe == GPD_ALL_OUTPUT) && !acc_rd)
        ##1 (acc_rd && sel_data && !acc_wr);
    endsequence

    a_data_addr_dual : assert property (
        s_write_then_read |=> (acc_rd_valid && (acc_rdata == $past(acc_wdata, 2)))
    ) else $error("Data address read did not return the latched byte.");

    // First cycle after reset: every pin is an input and the latch is clear.
    a_reset_state : assert property (
        !$past(rst_n) |->
            ((port_three_pins_oe == GPD_DIR_RST) && (port_three_pins_out == GPD_LATCH_RST))
    ) else $error("Port did not come out of reset as all inputs with a clear latch.");

    // Reads of other addresses give no valid pulse and zero data.
    a_unmapped_read : assert property (
        (acc_rd && !sel_data && !sel_dir) |=> (!acc_rd_valid && (acc_rdata == GPD_UNMAPPED_READ))
    ) else $error("Unmapped read answered.");

    // Writes to other addresses must leave both the latch and the direction alone.
    a_unmapped_write : assert property (
        (acc_wr && !sel_data && !sel_dir) |=>
            ($stable(port_three_pins_out) && $stable(port_three_pins_oe))
    ) else $error("Unmapped write changed the port state.");

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks on the answer timing of the byte access bus and on port state that accesses must leave alone.

    // Read data stand until the next read strobe, so a late pickup still sees them.
    a_rdata_holds : assert property (
        !acc_rd |=> $stable(acc_rdata)
    ) else $error("Read data changed without a read strobe.");

    // The valid pulse lasts one cycle per hitting read strobe and follows a read strobe only.
    a_valid_one_cycle : assert property (
        !acc_rd |=> !acc_rd_valid
    ) else $error("Read valid pulse without a read strobe.");

    // Every data read is answered exactly one edge after its strobe.
    a_data_read_valid : assert property (
        (acc_rd && sel_data) |=> acc_rd_valid
    ) else $error("Data read was not answered with a valid pulse.");

    // Driven pin levels only move on a data write; reads never disturb the latch.
    a_out_only_on_write : assert property (
        !(acc_wr && sel_data) |=> $stable(port_three_pins_out)
    ) else $error("Pin output level changed without a data write.");

    // A direction read leaves the stored direction bits untouched.
    a_dir_read_keeps : assert property (
        (acc_rd && sel_dir && !acc_wr) |=> $stable(port_three_pins_oe)
    ) else $error("Direction read disturbed the stored direction bits.");

    ////////////////////////////////////////////////////////////////////////////////////////
    // Scenarios worth seeing in simulation.
    c_mixed_read : cover property (
        acc_rd && sel_data && (bank_bus.dir != 8'h00) && (bank_bus.dir != GPD_ALL_OUTPUT)
    );

    c_dir_read : cover property (
        acc_rd && sel_dir
    );

    // Bit clear on the direction register: read, then write back one bit cleared.
    c_dir_rmw : cover property (
        (acc_rd && sel_dir) ##2 (acc_wr && sel_dir && (acc_wdata == 8'hFE))
    );

    // Bit set on the data register while some pins are inputs.
    c_data_rmw : cover property (
        (acc_rd && sel_data && (bank_bus.dir != GPD_ALL_OUTPUT)) ##2 (acc_wr && sel_data)
    );

    // Write and read of the data address on back-to-back edges.
    c_write_read : cover property (
        s_write_then_read
    );

endmodule

`default_nettype wire

// *** test/gpd_cpu_model.sv ***
// Processor core model issuing byte reads, byte writes and bit operations on the port.
`timescale 1ns/1ps
`default_nettype none

module gpd_cpu_model
    import gpd_pkg::*;
(
    // Clock
    input  wire logic                 mclk,
    // Byte access bus
    output logic      [15:0]          acc_addr,
    output logic                      acc_rd,
    output logic                      acc_wr,
    output logic      [GPD_WIDTH-1:0] acc_wdata,
    input  wire logic [GPD_WIDTH-1:0] acc_rdata,
    input  wire logic                 acc_rd_valid
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus from time zero, so nothing is requested while reset is held.
    initial begin
        acc_addr  = 16'h0000;
        acc_rd    = 1'b0;
        acc_wr    = 1'b0;
        acc_wdata = 8'h00;
    end

    // One read; the answer is taken one edge after the strobe edge.
    // Address is inverted on release so a stale value never looks valid.
    task automatic rd(input gpd_addr_type a, output gpd_byte_type d, output logic v);
        @(posedge mclk);
        acc_rd   <= 1'b1;
        acc_addr <= a;
        @(posedge mclk);
        acc_rd   <= 1'b0;
        acc_addr <= ~a;
        #1;
        d = acc_rdata;
        v = acc_rd_valid;
    endtask

    // One whole-byte write; state is visible just after the strobe is taken.
    task automatic wr(input gpd_addr_type a, input gpd_byte_type d);
        @(posedge mclk);
        acc_wr    <= 1'b1;
        acc_addr  <= a;
        acc_wdata <= d;
        @(posedge mclk);
        acc_wr    <= 1'b0;
        acc_addr  <= ~a;
        acc_wdata <= ~d;
        #1;
    endtask

    // Write then read the same address on back-to-back edges.
    task automatic wr_rd(input gpd_addr_type a, input gpd_byte_type wd,
                         output gpd_byte_type d, output logic v);
        @(posedge mclk);
        acc_wr    <= 1'b1;
        acc_addr  <= a;
        acc_wdata <= wd;
        @(posedge mclk);
        acc_wr    <= 1'b0;
        acc_rd    <= 1'b1;
        acc_wdata <= ~wd;
        @(posedge mclk);
        acc_rd    <= 1'b0;
        acc_addr  <= ~a;
        #1;
        d = acc_rdata;
        v = acc_rd_valid;
    endtask

    // Bit set or clear: read the byte, change one bit, write the byte back.
    task automatic bit_op(input gpd_addr_type a, input int n, input logic s);
        gpd_byte_type d;
        logic         v;
        rd(a, d, v);
        d[n] = s;
        wr(a, d);
    endtask
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking testbench of the eight-pin port data and direction logic.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import gpd_pkg::*;

    logic         mclk;
    logic         rst_n;
    logic [15:0]  acc_addr;
    logic         acc_rd;
    logic         acc_wr;
    gpd_byte_type acc_wdata;
    gpd_byte_type acc_rdata;
    logic         acc_rd_valid;
    gpd_byte_type pins_in;
    gpd_byte_type pins_out;
    gpd_byte_type pins_oe;
    gpd_byte_type rd_d;
    logic         rd_v;
    int           num_errors;
    int           n_checks;

    ////////////////////////////////////////////////////////////////////////////////
    // Design and processor model.
    gpd_port dut_u (.mclk(mclk), .rst_n(rst_n), .acc_addr(acc_addr), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_rd_valid(acc_rd_valid), .port_three_pins_in(pins_in),
        .port_three_pins_out(pins_out), .port_three_pins_oe(pins_oe));
    gpd_cpu_model cpu_u (.mclk(mclk), .acc_addr(acc_addr), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_rd_valid(acc_rd_valid));

    // Clock at 250 MHz.
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison and closing report.
    task automatic chk(input string name, input gpd_byte_type seen, input gpd_byte_type exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read the data byte and check both the answer strobe and the value.
    task automatic rd_data(input gpd_byte_type exp);
        cpu_u.rd(GPD_DATA_ADDR, rd_d, rd_v);
        chk("rd_valid", {7'h00, rd_v}, 8'h01);
        chk("data_read", rd_d, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset_state();
        chk("oe_reset", pins_oe, 8'h00);
        chk("out_reset", pins_out, 8'h00);
        chk("valid_reset", {7'h00, acc_rd_valid}, 8'h00);
    endtask

    // Bit set on the data byte picks up input pin levels into the latch.
    task automatic t_bit_set_data();
        @(posedge mclk);
        pins_in <= 8'h55;
        cpu_u.wr(GPD_DIR_ADDR, 8'h3F);
        cpu_u.wr(GPD_DATA_ADDR, 8'h80);
        rd_data(8'h40);
        cpu_u.bit_op(GPD_DATA_ADDR, 0, 1'b1);
        chk("out_after_set", pins_out, 8'h41);
        chk("oe_after_set", pins_oe, 8'h3F);
        cpu_u.wr(GPD_DATA_ADDR, 8'h81);
        chk("out_shadow", pins_out, 8'h81);
    endtask

    // Bit clear on the direction byte turns the input pins into outputs.
    task automatic t_bit_clear_dir();
        cpu_u.rd(GPD_DIR_ADDR, rd_d, rd_v);
        chk("dir_read", rd_d, GPD_DIR_READ_VAL);
        chk("dir_valid", {7'h00, rd_v}, 8'h01);
        cpu_u.bit_op(GPD_DIR_ADDR, 0, 1'b0);
        chk("oe_after_clr", pins_oe, 8'hFE);
        cpu_u.wr(GPD_DIR_ADDR, 8'h3E);
        chk("oe_shadow", pins_oe, 8'h3E);
        rd_data(8'h41);
    endtask

    // All outputs follow the latch; all inputs show the pins.
    task automatic t_out_in();
        @(posedge mclk);
        pins_in <= 8'h5A;
        cpu_u.wr(GPD_DIR_ADDR, 8'hFF);
        cpu_u.wr_rd(GPD_DATA_ADDR, 8'h3C, rd_d, rd_v);
        chk("b2b_valid", {7'h00, rd_v}, 8'h01);
        chk("b2b_read", rd_d, 8'h3C);
        cpu_u.wr(GPD_DATA_ADDR, 8'hA5);
        chk("out_all", pins_out, 8'hA5);
        rd_data(8'hA5);
        cpu_u.wr(GPD_DIR_ADDR, 8'h00);
        chk("oe_none", pins_oe, 8'h00);
        rd_data(8'h5A);
        @(posedge mclk);
        pins_in <= 8'hC3;
        rd_data(8'hC3);
    endtask

    // Unmapped accesses answer nothing and change nothing.
    task automatic t_unmapped();
        cpu_u.wr(16'hFFD7, 8'h3C);
        chk("out_unmapped", pins_out, 8'hA5);
        cpu_u.rd(16'hFFD5, rd_d, rd_v);
        chk("valid_unmapped", {7'h00, rd_v}, 8'h00);
        chk("data_unmapped", rd_d, GPD_UNMAPPED_READ);
    endtask

    // Reset in mid-run clears direction and latch at once.
    task automatic t_mid_reset();
        cpu_u.wr(GPD_DIR_ADDR, 8'hF0);
        @(posedge mclk);
        rst_n <= 1'b0;
        #1;
        chk("oe_midreset", pins_oe, 8'h00);
        chk("out_midreset", pins_out, 8'h00);
        @(posedge mclk);
        rst_n <= 1'b1;
        rd_data(8'hC3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and a guard against a hang.
    initial begin
        num_errors = 0;
        n_checks   = 0;
        rst_n      = 1'b0;
        pins_in    = 8'h00;
        repeat (2) @(posedge mclk);
        #1;
        t_reset_state();
        @(posedge mclk);
        rst_n <= 1'b1;
        t_bit_set_data();
        t_bit_clear_dir();
        t_out_in();
        t_unmapped();
        t_mid_reset();
        print_verdict();
    end

    initial begin
        #40000;
        num_errors++;
        print_verdict();
    end
endmodule

`default_nettype wire
